/* File: logic/lpr_pkg.sv */
// Shared constants, types and helpers for the LED PWM register bank.
// Assumes a single 40 MHz ref_clk domain; all pin inputs are synchronised by the top.
package lpr_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int NUM_CH = 28;
  localparam int PWM_STEPS = 256;
  localparam int PWM_SLOW_HZ = 3000;
  localparam int PWM_FAST_HZ = 22000;
  // Clock cycles per PWM step, rounded down so the period never runs long
  localparam int PWM_SLOW_DIV = CLK_HZ / (PWM_SLOW_HZ * PWM_STEPS);
  localparam int PWM_FAST_DIV = CLK_HZ / (PWM_FAST_HZ * PWM_STEPS);

  // Bus address: fixed high part, strap bits, write-only direction bit
  localparam logic [4:0] DEV_ADDR_HI = 5'h0f;
  localparam logic DIR_WRITE = 1'h0;
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_SCL = 2'h1;
  localparam logic [1:0] STRAP_SDA = 2'h2;
  localparam logic [1:0] STRAP_VCC = 2'h3;

  // Register offsets
  localparam logic [7:0] OFS_SOFT_SHUTDOWN = 8'h00;
  localparam logic [7:0] OFS_DUTY_FIRST = 8'h05;
  localparam logic [7:0] OFS_DUTY_LAST = 8'h20;
  localparam logic [7:0] OFS_SHADOW_APPLY = 8'h25;
  localparam logic [7:0] OFS_CTRL_FIRST = 8'h2a;
  localparam logic [7:0] OFS_CTRL_LAST = 8'h45;
  localparam logic [7:0] OFS_GLOBAL_LED = 8'h4a;
  localparam logic [7:0] OFS_PWM_FREQ = 8'h4b;
  localparam logic [7:0] OFS_SOFT_RESET = 8'h4f;
  localparam logic [7:0] APPLY_KEY = 8'h00;
  localparam logic [7:0] RESET_KEY = 8'h00;

  // Field positions and reset values
  localparam int SOFT_RUN_BIT = 0;
  localparam int CH_ON_BIT = 0;
  localparam int SCALE_LSB = 1;
  localparam int GLOBAL_DIS_BIT = 0;
  localparam int FREQ_SEL_BIT = 0;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Shadow memory layout: duty at index 0.., control at index 32..
  localparam int MEM_AW = 6;
  localparam logic [5:0] CTRL_BASE_IDX = 6'h20;
  localparam logic [5:0] MEM_LAST_IDX = 6'h3f;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } lpr_wr_t;

  typedef struct packed {
    logic on;
    logic [1:0] scale;
    logic [7:0] duty;
  } lpr_chan_t;

  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                    input logic [7:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [5:0] mem_index(input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (a >= OFS_CTRL_FIRST) begin
      d = a - OFS_CTRL_FIRST;
      return CTRL_BASE_IDX + d[5:0];
    end
    d = a - OFS_DUTY_FIRST;
    return d[5:0];
  endfunction
endpackage

/* File: logic/lpr_shadow_mem.sv */
// Shadow storage for duty and channel control bytes, one write and one registered read port.
// Assumes clr and all controls come from the ref_clk domain.
`timescale 1ns/1ps
module lpr_shadow_mem #(
  parameter int AW = 6,
  parameter int DW = 8
) (
  input wire logic ref_clk,
  input wire logic clr,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem_q [2**AW];

  // Flop array so a reset-by-write can clear every entry in one cycle
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 2**AW; i++) begin
      if (clr) begin
        mem_q[i] <= '0;
      end else if (we && (waddr == AW'(i))) begin
        mem_q[i] <= wdata;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clr) begin
      rdata <= '0;
    end else begin
      rdata <= mem_q[raddr];
    end
  end
endmodule // lpr_shadow_mem

/* File: logic/lpr_i2c_slave.sv */
// Write-only two-wire bus slave: address match, register pointer, data bytes.
// Assumes scl_s and sda_s are already passed through two synchroniser flops.
`timescale 1ns/1ps
module lpr_i2c_slave
  import lpr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl_s,
  input wire logic sda_s,
  input wire logic [1:0] strap,
  output logic sda_oe,
  output logic bus_start,
  output logic wr_valid,
  output lpr_wr_t wr
);
  typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_REG, ST_DATA, ST_ACK} lpr_bus_st_t;

  lpr_bus_st_t state_q;
  lpr_bus_st_t after_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic [7:0] shift_q;
  logic [3:0] cnt_q;
  logic [7:0] ptr_q;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  assign scl_rise = scl_s && !scl_prev_q;
  assign scl_fall = !scl_s && scl_prev_q;
  assign start_cond = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  assign stop_cond = scl_s && scl_prev_q && !sda_prev_q && sda_s;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_prev_q <= 1'h1;
      sda_prev_q <= 1'h1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      after_q <= ST_IDLE;
      shift_q <= 8'h00;
      cnt_q <= 4'h0;
      ptr_q <= 8'h00;
      sda_oe <= 1'h0;
      bus_start <= 1'h0;
      wr_valid <= 1'h0;
      wr <= '0;
    end else begin
      wr_valid <= 1'h0;
      bus_start <= start_cond;
      if (start_cond) begin
        state_q <= ST_DEV;
        cnt_q <= 4'h0;
        sda_oe <= 1'h0;
      end else if (stop_cond) begin
        state_q <= ST_IDLE;
        sda_oe <= 1'h0;
      end else begin
        case (state_q)
          ST_DEV, ST_REG, ST_DATA: begin
            if (scl_rise && cnt_q != 4'h8) begin
              shift_q <= {shift_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'h8) begin
              state_q <= ST_ACK;
              sda_oe <= 1'h1;
              if (state_q == ST_DEV) begin
                after_q <= ST_REG;
                // Reads and foreign addresses get no acknowledge
                if (shift_q != {DEV_ADDR_HI, strap, DIR_WRITE}) begin
                  state_q <= ST_IDLE;
                  sda_oe <= 1'h0;
                end
              end else if (state_q == ST_REG) begin
                after_q <= ST_DATA;
                ptr_q <= shift_q;
              end else begin
                after_q <= ST_DATA;
                wr_valid <= 1'h1;
                wr.addr <= ptr_q;
                wr.data <= shift_q;
                ptr_q <= ptr_q + 8'h01;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              sda_oe <= 1'h0;
              state_q <= after_q;
              cnt_q <= 4'h0;
            end
          end
          default: begin
            sda_oe <= 1'h0;
          end
        endcase
      end
    end
  end
endmodule // lpr_i2c_slave

/* File: logic/lpr_led_pwm_bank.sv */
// Top of the LED PWM register bank: pin synchronisers, register writes,
// shadow-to-active copy and the shared PWM compare.
// Assumes open-drain data pin resolved outside; sda_oe high pulls the line low.
`timescale 1ns/1ps
module lpr_led_pwm_bank
  import lpr_pkg::*;
#(
  parameter int CHANNELS = NUM_CH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic ad_pin,
  input wire logic hw_shutdown_n,
  output logic [CHANNELS-1:0] led_channel_output,
  output logic [CHANNELS-1:0][1:0] current_scale
);
  localparam logic [5:0] SLOW_DIV_M1 = 6'(PWM_SLOW_DIV - 1);
  localparam logic [5:0] FAST_DIV_M1 = 6'(PWM_FAST_DIV - 1);

  // Pin synchronisers: {scl, sda, strap, shutdown}
  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  logic scl_s;
  logic sda_s;
  logic ad_s;
  logic sdb_s;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_meta_q <= 4'hf;
      pin_sync_q <= 4'hf;
    end else begin
      pin_meta_q <= {scl_pin, sda_in, ad_pin, hw_shutdown_n};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign scl_s = pin_sync_q[3];
  assign sda_s = pin_sync_q[2];
  assign ad_s = pin_sync_q[1];
  assign sdb_s = pin_sync_q[0];

  // Strap decode: watch the strap pin against both bus lines from each start
  logic bus_start;
  logic strap_diff_scl_q;
  logic strap_diff_sda_q;
  logic strap_high_q;
  logic [1:0] strap;

  always_ff @(posedge ref_clk) begin
    if (rst || bus_start) begin
      strap_diff_scl_q <= 1'h0;
      strap_diff_sda_q <= 1'h0;
    end else begin
      strap_diff_scl_q <= strap_diff_scl_q | (ad_s ^ scl_s);
      strap_diff_sda_q <= strap_diff_sda_q | (ad_s ^ sda_s);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      strap_high_q <= 1'h0;
    end else if (bus_start) begin
      strap_high_q <= ad_s;
    end
  end

  // Address byte toggles both lines, so a fixed level differs from each of them
  always_comb begin
    if (!strap_diff_scl_q) begin
      strap = STRAP_SCL;
    end else if (!strap_diff_sda_q) begin
      strap = STRAP_SDA;
    end else if (strap_high_q) begin
      strap = STRAP_VCC;
    end else begin
      strap = STRAP_GND;
    end
  end

  logic wr_valid;
  lpr_wr_t wr;
  logic slave_oe;

  lpr_i2c_slave u_slave (
    .ref_clk(ref_clk),
    .rst(rst),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .strap(strap),
    .sda_oe(slave_oe),
    .bus_start(bus_start),
    .wr_valid(wr_valid),
    .wr(wr)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sda_out <= 1'h0;
      sda_oe <= 1'h0;
    end else begin
      sda_out <= 1'h0;
      sda_oe <= slave_oe;
    end
  end

  // Register write decode
  logic soft_clr;
  logic apply_hit;
  logic shadow_we;
  logic soft_run_q;
  logic global_dis_q;
  logic pwm_freq_sel;

  always_comb begin
    soft_clr = 1'h0;
    apply_hit = 1'h0;
    shadow_we = 1'h0;
    if (wr_valid) begin
      if (wr.addr == OFS_SOFT_RESET) begin
        soft_clr = (wr.data == RESET_KEY);
      end else if (wr.addr == OFS_SHADOW_APPLY) begin
        apply_hit = (wr.data == APPLY_KEY);
      end else if (in_range(wr.addr, OFS_DUTY_FIRST, OFS_DUTY_LAST)) begin
        shadow_we = 1'h1;
      end else if (in_range(wr.addr, OFS_CTRL_FIRST, OFS_CTRL_LAST)) begin
        shadow_we = 1'h1;
      end
    end
  end

  // Shutdown never touches stored state; only reset or the reset key clears it
  always_ff @(posedge ref_clk) begin
    if (rst || soft_clr) begin
      soft_run_q <= REG_RESET[SOFT_RUN_BIT];
      global_dis_q <= REG_RESET[GLOBAL_DIS_BIT];
      pwm_freq_sel <= REG_RESET[FREQ_SEL_BIT];
    end else if (wr_valid) begin
      if (wr.addr == OFS_SOFT_SHUTDOWN) begin
        soft_run_q <= wr.data[SOFT_RUN_BIT];
      end else if (wr.addr == OFS_GLOBAL_LED) begin
        global_dis_q <= wr.data[GLOBAL_DIS_BIT];
      end else if (wr.addr == OFS_PWM_FREQ) begin
        pwm_freq_sel <= wr.data[FREQ_SEL_BIT];
      end
    end
  end

  // Shadow copy engine: walks every shadow entry after an apply write
  logic copy_busy_q;
  logic [5:0] copy_idx_q;
  logic load_valid_q;
  logic [5:0] load_idx_q;
  logic [7:0] shadow_rdata;

  lpr_shadow_mem #(
    .AW(MEM_AW),
    .DW(8)
  ) u_shadow (
    .ref_clk(ref_clk),
    .clr(rst || soft_clr),
    .we(shadow_we),
    .waddr(mem_index(wr.addr)),
    .wdata(wr.data),
    .raddr(copy_idx_q),
    .rdata(shadow_rdata)
  );

  // A second apply during a walk restarts it so every entry ends up current
  always_ff @(posedge ref_clk) begin
    if (rst || soft_clr) begin
      copy_busy_q <= 1'h0;
      copy_idx_q <= 6'h00;
      load_valid_q <= 1'h0;
      load_idx_q <= 6'h00;
    end else begin
      load_valid_q <= copy_busy_q;
      load_idx_q <= copy_idx_q;
      if (apply_hit) begin
        copy_busy_q <= 1'h1;
        copy_idx_q <= 6'h00;
      end else if (copy_busy_q) begin
        copy_idx_q <= copy_idx_q + 6'h01;
        copy_busy_q <= (copy_idx_q != MEM_LAST_IDX);
      end
    end
  end

  lpr_chan_t chan_q [CHANNELS];

  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < CHANNELS; i++) begin
      if (rst || soft_clr) begin
        chan_q[i] <= '0;
      end else if (load_valid_q) begin
        if (load_idx_q == 6'(i)) begin
          chan_q[i].duty <= shadow_rdata;
        end else if (load_idx_q == CTRL_BASE_IDX + 6'(i)) begin
          chan_q[i].on <= shadow_rdata[CH_ON_BIT];
          chan_q[i].scale <= shadow_rdata[SCALE_LSB +: 2];
        end
      end
    end
  end

  // Shared time base: one prescaler and one 8-bit counter for all channels
  logic [5:0] presc_q;
  logic [7:0] pwm_cnt_q;
  logic [5:0] div_m1;

  assign div_m1 = pwm_freq_sel ? FAST_DIV_M1 : SLOW_DIV_M1;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      presc_q <= 6'h00;
      pwm_cnt_q <= 8'h00;
    end else if (presc_q >= div_m1) begin
      presc_q <= 6'h00;
      pwm_cnt_q <= pwm_cnt_q + 8'h01;
    end else begin
      presc_q <= presc_q + 6'h01;
    end
  end

  logic run_ok;

  assign run_ok = soft_run_q && !global_dis_q && sdb_s;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      led_channel_output <= '0;
      current_scale <= '0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        // Counter below duty gives duty/256 on time; zero never turns on
        led_channel_output[i] <= run_ok && chan_q[i].on
                                 && (pwm_cnt_q < chan_q[i].duty);
        current_scale[i] <= chan_q[i].scale;
      end
    end
  end
endmodule // lpr_led_pwm_bank

/* File: sim/lpr_checker.sv */
// Port-level checks for the LED PWM register bank.
// Assumes one ref_clk domain with synchronous active-high rst.
`timescale 1ns/1ps
module lpr_checker
  import lpr_pkg::*;
#(
  parameter int CHANNELS = NUM_CH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl_pin,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic ad_pin,
  input wire logic hw_shutdown_n,
  input wire logic [CHANNELS-1:0] led_channel_output,
  input wire logic [CHANNELS-1:0][1:0] current_scale
);
  logic scl_q;
  logic seen_q;
  logic [7:0] quiet_q;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  always_ff @(posedge ref_clk) begin
    scl_q <= scl_pin;
  end
  // Bus idle time; apply walks and one-cycle reset clears end well inside 255 cycles
  always_ff @(posedge ref_clk) begin
    if (rst || scl_q != scl_pin) begin
      quiet_q <= 8'h00;
    end else if (quiet_q != 8'hff) begin
      quiet_q <= quiet_q + 8'h01;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seen_q <= 1'b0;
    end else if (scl_q && !scl_pin) begin
      seen_q <= 1'b1;
    end
  end
  property p_rst_clear;
    @(posedge ref_clk) disable iff (1'b0)
    rst |=> !sda_oe && led_channel_output == '0 && current_scale == '0;
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("outputs not cleared by reset");
  property p_dark_idle;
    !seen_q |-> led_channel_output == '0;
  endproperty
  a_dark_idle: assert property (p_dark_idle)
    else $error("channel lit before any bus traffic");
  property p_hw_off;
    !hw_shutdown_n [*5] |-> led_channel_output == '0;
  endproperty
  a_hw_off: assert property (p_hw_off)
    else $error("channel lit in hardware shutdown");
  property p_ack_hold;
    $rose(sda_oe) |=> sda_oe [*5];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("acknowledge dropped early");
  property p_ack_end;
    $rose(sda_oe) |-> ##[6:16] !sda_oe;
  endproperty
  a_ack_end: assert property (p_ack_end)
    else $error("acknowledge not released");
  property p_ack_idle;
    quiet_q == 8'hff |-> !sda_oe;
  endproperty
  a_ack_idle: assert property (p_ack_idle)
    else $error("data line pulled on idle bus");
  property p_scale_still;
    quiet_q == 8'hff |-> $stable(current_scale);
  endproperty
  a_scale_still: assert property (p_scale_still)
    else $error("scale changed without a bus write");
  property p_open_drain;
    sda_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data pin driven high");
  c_ack: cover property ($rose(sda_oe));
  c_led_on: cover property (|led_channel_output);
  c_hw_cut: cover property (|led_channel_output ##1 !hw_shutdown_n);
endmodule // lpr_checker

bind lpr_led_pwm_bank lpr_checker #(.CHANNELS(CHANNELS)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .scl_pin(scl_pin), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .ad_pin(ad_pin), .hw_shutdown_n(hw_shutdown_n),
  .led_channel_output(led_channel_output), .current_scale(current_scale));

/* File: sim/lpr_i2c_host.sv */
// Two-wire bus master model for the LED bank's serial port.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
module lpr_i2c_host (
  output logic scl,
  output logic sda_low,
  input wire logic sda_line
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Clock runs only inside frames; data is read at the end of the high phase
  task automatic put_bit(input logic b, output logic got);
    #20 sda_low = !b;
    #80 scl = 1'b1;
    #95 got = sda_line;
    #5 scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] q[$], output int acks);
    logic g;
    acks = 0;
    #100 sda_low = 1'b1;
    #100 scl = 1'b0;
    foreach (q[i]) begin
      for (int b = 7; b >= 0; b--) put_bit(q[i][b], g);
      put_bit(1'b1, g);
      if (g) break; // Abort on refusal
      acks++;
    end
    #20 sda_low = 1'b1;
    #80 scl = 1'b1;
    #100 sda_low = 1'b0;
    #300;
  endtask
endmodule // lpr_i2c_host

/* File: sim/tb_top.sv */
// Self-checking bench for the LED PWM register bank.
// Assumes the host model and the bound checker compile alongside.
`timescale 1ns/1ps
module tb_top
  import lpr_pkg::*;
;
  localparam logic [7:0] DEV0 = {DEV_ADDR_HI, STRAP_GND, DIR_WRITE};
  logic ref_clk;
  logic rst;
  logic scl;
  logic host_low;
  logic [1:0] ad_sel = STRAP_GND;
  logic hw_shutdown_n = 1'b1;
  logic sda_out;
  logic sda_oe;
  logic [NUM_CH-1:0] led;
  logic [NUM_CH-1:0][1:0] scale;
  logic [31:0] on_cnt [4];
  logic [7:0] duty4 [4] = '{8'h80, 8'h00, 8'hff, 8'h40};
  logic [7:0] dark [4] = '{default: 8'h00};
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int sync_err;
  wire sda_line;
  wire ad_pin;
  assign sda_line = !(host_low || sda_oe);
  assign ad_pin = ad_sel == STRAP_GND ? 1'b0 : ad_sel == STRAP_VCC ? 1'b1 :
                  ad_sel == STRAP_SCL ? scl : sda_line;
  lpr_i2c_host u_host (.scl(scl), .sda_low(host_low), .sda_line(sda_line));
  lpr_led_pwm_bank u_dut (
    .ref_clk(ref_clk), .rst(rst), .scl_pin(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .ad_pin(ad_pin), .hw_shutdown_n(hw_shutdown_n),
    .led_channel_output(led), .current_scale(scale));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, msg, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] q[$], input int exp_acks);
    int n;
    u_host.xfer(q, n);
    chk(n, exp_acks, "ack count");
    @(negedge ref_clk);
  endtask
  // Whole-period on-time per channel; phase does not matter over one period
  task automatic expect_on(input int div, input logic [7:0] d [4]);
    repeat (200) @(negedge ref_clk);
    on_cnt = '{default: 32'h0};
    sync_err = 0;
    repeat (256 * div) begin
      @(negedge ref_clk);
      for (int i = 0; i < 4; i++) on_cnt[i] += 32'(led[i]);
      if (led[3] && !led[2]) sync_err++;
    end
    for (int i = 0; i < 4; i++) chk(on_cnt[i], 32'(d[i]) * 32'(div), "on time");
    chk(sync_err, 0, "channels out of step");
  endtask
  task automatic t_shadow();
    chk(scale, 0, "scale after reset");
    chk(led, 0, "outputs after reset");
    wr('{DEV0, OFS_SOFT_SHUTDOWN, 8'h01}, 3);
    wr('{DEV0, OFS_PWM_FREQ, 8'h01}, 3);
    wr('{DEV0, OFS_CTRL_FIRST, 8'h01, 8'h03, 8'h05, 8'h07}, 6);
    wr('{DEV0, OFS_DUTY_FIRST, 8'h80, 8'h00, 8'hff, 8'h40}, 6);
    wr('{DEV0, OFS_SHADOW_APPLY, 8'h55}, 3);
    expect_on(PWM_FAST_DIV, dark);
    chk(scale, 0, "scale before apply");
    wr('{DEV0, OFS_SHADOW_APPLY, APPLY_KEY}, 3);
    expect_on(PWM_FAST_DIV, duty4);
    chk(scale[3:0], 8'he4, "scale codes");
  endtask
  task automatic t_slow();
    wr('{DEV0, OFS_PWM_FREQ, 8'h00}, 3);
    expect_on(PWM_SLOW_DIV, duty4);
    wr('{DEV0, OFS_PWM_FREQ, 8'h01}, 3);
  endtask
  task automatic t_gates();
    wr('{DEV0, OFS_GLOBAL_LED, 8'h01}, 3);
    expect_on(PWM_FAST_DIV, dark);
    wr('{DEV0, OFS_GLOBAL_LED, 8'h00}, 3);
    wr('{DEV0, OFS_SOFT_SHUTDOWN, 8'h00}, 3);
    expect_on(PWM_FAST_DIV, dark);
    chk(scale[3:0], 8'he4, "scale in shutdown");
    wr('{DEV0, OFS_SOFT_SHUTDOWN, 8'h01}, 3);
    hw_shutdown_n = 1'b0;
    expect_on(PWM_FAST_DIV, dark);
    hw_shutdown_n = 1'b1;
    expect_on(PWM_FAST_DIV, duty4);
  endtask
  // Each strap source must match its own code and refuse a neighbour's
  task automatic t_strap();
    for (int s = 0; s < 4; s++) begin
      ad_sel = 2'(s);
      wr('{{DEV_ADDR_HI, 2'(s), DIR_WRITE}, OFS_GLOBAL_LED, 8'h00}, 3);
      wr('{{DEV_ADDR_HI, 2'(s + 1), DIR_WRITE}, OFS_GLOBAL_LED, 8'h01}, 0);
    end
    ad_sel = STRAP_GND;
    wr('{{DEV_ADDR_HI, STRAP_GND, 1'b1}, OFS_GLOBAL_LED, 8'h01}, 0);
    wr('{DEV0, 8'h50, 8'h01}, 3);
    wr('{DEV0, OFS_CTRL_FIRST, 8'h00}, 3);
    wr('{DEV0, OFS_SHADOW_APPLY, APPLY_KEY}, 3);
    expect_on(PWM_FAST_DIV, '{8'h00, 8'h00, 8'hff, 8'h40});
  endtask
  task automatic t_soft_reset();
    wr('{DEV0, OFS_SOFT_RESET, RESET_KEY}, 3);
    expect_on(PWM_FAST_DIV, dark);
    chk(scale, 0, "scale after reset command");
  endtask
  initial begin
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    t_shadow();
    t_slow();
    t_gates();
    t_strap();
    t_soft_reset();
    wrap_up();
  end
endmodule // tb_top
